// ===== sbg_pkg.sv
// Shared constants and types for the shared-bus flash/SRAM host controller.
// Assumes a 100 MHz system clock and a stacked flash + SRAM part on one bus.
package sbg_pkg;

  // Clock and timing figures
  localparam int unsigned SBG_CLK_PERIOD_NS = 10;   // System clock period
  localparam int unsigned SBG_RESET_LOW_NS  = 100;  // Least flash reset pulse
  localparam int unsigned SBG_ACCESS_NS     = 70;   // Read or write strobe time
  localparam int unsigned SBG_FLOAT_NS      = 25;   // Output float after strobe
  localparam int unsigned SBG_SYNC_STAGES   = 2;    // Pin synchroniser depth

  // Derived cycle counts (least times rounded up)
  localparam int unsigned SBG_RESET_LOW_CYC =
    (SBG_RESET_LOW_NS + SBG_CLK_PERIOD_NS - 1) / SBG_CLK_PERIOD_NS;
  localparam int unsigned SBG_ACCESS_CYC =
    (SBG_ACCESS_NS + SBG_CLK_PERIOD_NS - 1) / SBG_CLK_PERIOD_NS;
  localparam int unsigned SBG_FLOAT_CYC =
    (SBG_FLOAT_NS + SBG_CLK_PERIOD_NS - 1) / SBG_CLK_PERIOD_NS;
  localparam int unsigned SBG_SETUP_CYC  = 1;       // Address and select setup

  // Bus widths
  localparam int unsigned SBG_ADDR_W = 20;          // Word address width
  localparam int unsigned SBG_DATA_W = 16;          // Data bus width
  localparam int unsigned SBG_CNT_W  = 5;           // Phase counter width

  // Reset values
  localparam logic SBG_RP_N_RST = 1'b0;             // Flash held in reset

  // Target die, decoded once into selects
  typedef enum logic
  {
    SBG_TGT_FLASH = 1'b0,
    SBG_TGT_SRAM  = 1'b1
  } sbg_target_t;

  // User operation kinds
  typedef enum logic [1:0]
  {
    SBG_OP_READ     = 2'h0,                         // Array read, mode restored
    SBG_OP_WRITE    = 2'h1,                         // Plain bus write
    SBG_OP_READ_RAW = 2'h2                          // Read in current mode
  } sbg_op_t;

  // Bus phase states, Gray coded along the cycle
  typedef enum logic [1:0]
  {
    SBG_ST_IDLE   = 2'h0,
    SBG_ST_SETUP  = 2'h1,
    SBG_ST_STROBE = 2'h3,
    SBG_ST_HOLD   = 2'h2
  } sbg_state_t;

  // One user request
  typedef struct packed
  {
    sbg_target_t             target;
    sbg_op_t                 op;
    logic [SBG_ADDR_W-1:0]   addr;
    logic [SBG_DATA_W-1:0]   wdata;
  } sbg_req_t;

  // Shared-bus control pins, all low-active strobes except sram_select_high
  typedef struct packed
  {
    logic                    flash_ce_n;
    logic                    flash_we_n;
    logic                    flash_oe_n;
    logic                    sram_select_low_n;
    logic                    sram_select_high;
    logic                    sram_we_n;
    logic                    sram_oe_n;
    logic [SBG_ADDR_W-1:0]   addr;
  } sbg_pins_t;

  // Bus pins at rest: no die selected
  localparam sbg_pins_t SBG_PINS_IDLE = '{
    flash_ce_n: 1'b1, flash_we_n: 1'b1, flash_oe_n: 1'b1,
    sram_select_low_n: 1'b1, sram_select_high: 1'b0,
    sram_we_n: 1'b1, sram_oe_n: 1'b1, addr: '0};

endpackage

// ===== sbg_sync.sv
// Two-flop synchroniser for pin inputs of any width.
// Assumes each bit is a level; multi-bit data is only read once settled.
`timescale 1ns/10ps
module sbg_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Pin side
  input  wire logic [W-1:0] pin_i,
  // Synchronised side
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;                   // First stage, read by second only
  logic [W-1:0] sync_q;                   // Second stage

  // Two stages in series
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// ===== sbg_host.sv
// Host controller for a stacked flash + SRAM part on one shared bus.
// Assumes an asynchronous part, a power-good level and a processor reset pin.
//
// What this block does
// - Host issues read-array before array reads after program or erase
// - Flash reset follows the processor reset
// - Flash and SRAM never selected together
// - SRAM access allowed during flash program or erase
// - Only one die drives the shared bus
`timescale 1ns/10ps
module sbg_host #(
  parameter logic [7:0]  CMD_READ_ARRAY = 8'hff,  // Read-array command code
  parameter logic [7:0]  CMD_PROGRAM_A  = 8'h40,  // Program setup code
  parameter logic [7:0]  CMD_PROGRAM_B  = 8'h10,  // Alternate program setup
  parameter logic [7:0]  CMD_ERASE      = 8'h20,  // Block erase setup code
  parameter int unsigned RESET_LOW_CYC  = sbg_pkg::SBG_RESET_LOW_CYC,
  parameter int unsigned STROBE_CYC     = sbg_pkg::SBG_ACCESS_CYC + sbg_pkg::SBG_SYNC_STAGES,
  parameter int unsigned HOLD_CYC       = sbg_pkg::SBG_FLOAT_CYC
) (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  // System levels from pins
  input  wire logic                             cpu_reset_b,
  input  wire logic                             power_good,
  // User request port
  input  wire logic                             req_valid,
  input  wire sbg_pkg::sbg_req_t                req,
  output logic                                  req_ready,
  output logic                                  rsp_valid,
  output logic [sbg_pkg::SBG_DATA_W-1:0]        rsp_rdata,
  // Shared bus pins
  output sbg_pkg::sbg_pins_t                    pins,
  output logic                                  flash_reset_powerdown_n,
  input  wire logic [sbg_pkg::SBG_DATA_W-1:0]   dq_i,
  output logic [sbg_pkg::SBG_DATA_W-1:0]        dq_o,
  output logic                                  dq_oe
);

  // Refuse counts the phase counter cannot hold
  if (STROBE_CYC < sbg_pkg::SBG_SYNC_STAGES + 1 || STROBE_CYC > 31 ||
      HOLD_CYC < 1 || HOLD_CYC > 31 || RESET_LOW_CYC < 1 || RESET_LOW_CYC > 31)
  begin : g_bad_counts
    $error("sbg_host: phase counts out of range");
  end

  localparam logic [sbg_pkg::SBG_CNT_W-1:0] RST_N   = sbg_pkg::SBG_CNT_W'(RESET_LOW_CYC);
  localparam logic [sbg_pkg::SBG_CNT_W-1:0] STB_N   = sbg_pkg::SBG_CNT_W'(STROBE_CYC - 1);
  localparam logic [sbg_pkg::SBG_CNT_W-1:0] HLD_N   = sbg_pkg::SBG_CNT_W'(HOLD_CYC - 1);
  localparam logic [sbg_pkg::SBG_CNT_W-1:0] SET_N   = sbg_pkg::SBG_CNT_W'(sbg_pkg::SBG_SETUP_CYC - 1);

  // Synchronised inputs
  logic [1:0]                       lvl_s;    // {power_good, cpu_reset_b}
  logic                             pg_s;     // Power good, synced
  logic                             cpu_s;    // Processor out of reset, synced
  logic [sbg_pkg::SBG_DATA_W-1:0]   dq_s;     // Read data, synced

  sbg_sync #(.W(2)) u_lvl_sync (
    .clk    (clk),
    .rst_b  (rst_b),
    .pin_i  ({power_good, cpu_reset_b}),
    .sync_o (lvl_s)
  );

  sbg_sync #(.W(sbg_pkg::SBG_DATA_W)) u_dq_sync (
    .clk    (clk),
    .rst_b  (rst_b),
    .pin_i  (dq_i),
    .sync_o (dq_s)
  );

  assign pg_s  = lvl_s[1];
  assign cpu_s = lvl_s[0];

  // Selects and strobes from one decoded target, so no overlap is possible
  function automatic sbg_pkg::sbg_pins_t drive_pins(
    input sbg_pkg::sbg_target_t            tgt,
    input logic                            wr_stb,
    input logic                            rd_stb,
    input logic [sbg_pkg::SBG_ADDR_W-1:0]  addr
  );
    sbg_pkg::sbg_pins_t p;
    p      = sbg_pkg::SBG_PINS_IDLE;
    p.addr = addr;
    if (tgt == sbg_pkg::SBG_TGT_FLASH)
    begin
      p.flash_ce_n = 1'b0;
      p.flash_we_n = !wr_stb;
      p.flash_oe_n = !rd_stb;
    end
    else
    begin
      p.sram_select_low_n = 1'b0;
      p.sram_select_high  = 1'b1;
      p.sram_we_n         = !wr_stb;
      p.sram_oe_n         = !rd_stb;
    end
    return p;
  endfunction

  // Flash reset group
  logic [sbg_pkg::SBG_CNT_W-1:0] rst_cnt_q, rst_cnt_d;  // Remaining low cycles
  logic                          rp_n_q,    rp_n_d;     // Flash reset pin level
  logic                          rst_cause;             // Any reason to hold reset

  // Keep reset low while a cause stands and for the least pulse after it
  always_comb
  begin
    rst_cause = !pg_s || !cpu_s;
    rst_cnt_d = rst_cnt_q;
    rp_n_d    = 1'b0;
    if (rst_cause)
    begin
      rst_cnt_d = RST_N;
    end
    else if (rst_cnt_q != '0)
    begin
      rst_cnt_d = rst_cnt_q - 1'b1;
    end
    else
    begin
      rp_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_cnt_q <= RST_N;
      rp_n_q    <= sbg_pkg::SBG_RP_N_RST;
    end
    else
    begin
      rst_cnt_q <= rst_cnt_d;
      rp_n_q    <= rp_n_d;
    end
  end

  // Bus group
  sbg_pkg::sbg_state_t             st_q,    st_d;     // Bus phase
  logic [sbg_pkg::SBG_CNT_W-1:0]   cnt_q,   cnt_d;    // Cycles left in phase
  sbg_pkg::sbg_req_t               cur_q,   cur_d;    // Request in flight
  logic                            rest_q,  rest_d;   // Read-array write first
  logic                            dirty_q, dirty_d;  // Flash left array mode
  sbg_pkg::sbg_pins_t              pins_q,  pins_d;   // Registered bus pins
  logic [sbg_pkg::SBG_DATA_W-1:0]  dqo_q,   dqo_d;    // Data driven out
  logic                            dqoe_q,  dqoe_d;   // Data drive enable
  logic                            rdy_q,   rdy_d;    // Request accepted
  logic                            rv_q,    rv_d;     // Answer pulse
  logic [sbg_pkg::SBG_DATA_W-1:0]  rd_q,    rd_d;     // Answer data
  logic                            is_wr;             // Current phase writes
  logic [sbg_pkg::SBG_DATA_W-1:0]  wval;              // Value written now
  logic                            take;              // Request taken this edge
  logic                            flash_ok;          // Flash out of reset

  // Phase sequencing and pin drive
  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    cur_d    = cur_q;
    rest_d   = rest_q;
    dirty_d  = dirty_q;
    pins_d   = pins_q;
    dqo_d    = dqo_q;
    dqoe_d   = dqoe_q;
    rv_d     = 1'b0;
    rd_d     = rd_q;
    rdy_d    = 1'b0;
    flash_ok = rp_n_q;
    is_wr    = rest_q || (cur_q.op == sbg_pkg::SBG_OP_WRITE);
    wval     = rest_q ? sbg_pkg::SBG_DATA_W'(CMD_READ_ARRAY) : cur_q.wdata;
    take     = req_valid && rdy_q;
    if (!flash_ok)
    begin
      dirty_d = 1'b0;                             // Reset returns flash to array mode
    end
    case (st_q)
      sbg_pkg::SBG_ST_IDLE:
      begin
        // All selects off here: at least three gap cycles (two idle, one setup) between any two dies
        pins_d = sbg_pkg::SBG_PINS_IDLE;
        dqoe_d = 1'b0;
        if (take)
        begin
          cur_d  = req;
          rest_d = (req.target == sbg_pkg::SBG_TGT_FLASH) &&
                   (req.op == sbg_pkg::SBG_OP_READ) && dirty_q;
          st_d   = sbg_pkg::SBG_ST_SETUP;
          cnt_d  = SET_N;
        end
        else
        begin
          // Ready drops once a flash request waits with its reset low; SRAM still served
          rdy_d = !req_valid || req.target == sbg_pkg::SBG_TGT_SRAM || flash_ok;
        end
      end
      sbg_pkg::SBG_ST_SETUP:
      begin
        pins_d = drive_pins(cur_q.target, 1'b0, 1'b0, cur_q.addr);
        dqoe_d = is_wr;
        dqo_d  = wval;
        if (cnt_q == '0)
        begin
          st_d   = sbg_pkg::SBG_ST_STROBE;
          cnt_d  = STB_N;
          // Strobe asserts with select held low throughout
          pins_d = drive_pins(cur_q.target, is_wr, !is_wr, cur_q.addr);
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      sbg_pkg::SBG_ST_STROBE:
      begin
        if (cnt_q == '0)
        begin
          st_d   = sbg_pkg::SBG_ST_HOLD;
          cnt_d  = HLD_N;
          pins_d = drive_pins(cur_q.target, 1'b0, 1'b0, cur_q.addr);
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      sbg_pkg::SBG_ST_HOLD:
      begin
        // Synced data now reflects the pins late in the strobe
        if (cnt_q == HLD_N && !is_wr)
        begin
          rd_d = dq_s;
        end
        if (cnt_q == '0)
        begin
          pins_d = sbg_pkg::SBG_PINS_IDLE;
          dqoe_d = 1'b0;
          if (cur_q.target == sbg_pkg::SBG_TGT_FLASH && is_wr)
          begin
            // Track whether the flash has left read-array mode
            if (wval[7:0] == CMD_READ_ARRAY)
            begin
              dirty_d = 1'b0;
            end
            else if (wval[7:0] == CMD_PROGRAM_A || wval[7:0] == CMD_PROGRAM_B ||
                     wval[7:0] == CMD_ERASE)
            begin
              dirty_d = 1'b1;
            end
          end
          if (rest_q)
          begin
            rest_d = 1'b0;
            st_d   = sbg_pkg::SBG_ST_SETUP;
            cnt_d  = SET_N;
          end
          else
          begin
            rv_d = 1'b1;
            st_d = sbg_pkg::SBG_ST_IDLE;
          end
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default:
      begin
        st_d   = sbg_pkg::SBG_ST_IDLE;
        pins_d = sbg_pkg::SBG_PINS_IDLE;
        dqoe_d = 1'b0;
      end
    endcase
    // A flash cycle cut by reset is dropped; SRAM cycles go on
    if (!flash_ok && st_q != sbg_pkg::SBG_ST_IDLE &&
        cur_q.target == sbg_pkg::SBG_TGT_FLASH)
    begin
      st_d   = sbg_pkg::SBG_ST_IDLE;
      rest_d = 1'b0;
      pins_d = sbg_pkg::SBG_PINS_IDLE;
      dqoe_d = 1'b0;
      rv_d   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q    <= sbg_pkg::SBG_ST_IDLE;
      cnt_q   <= '0;
      cur_q   <= '0;
      rest_q  <= 1'b0;
      dirty_q <= 1'b0;
      pins_q  <= sbg_pkg::SBG_PINS_IDLE;
      dqo_q   <= '0;
      dqoe_q  <= 1'b0;
      rdy_q   <= 1'b0;
      rv_q    <= 1'b0;
      rd_q    <= '0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      cur_q   <= cur_d;
      rest_q  <= rest_d;
      dirty_q <= dirty_d;
      pins_q  <= pins_d;
      dqo_q   <= dqo_d;
      dqoe_q  <= dqoe_d;
      rdy_q   <= rdy_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
    end
  end

  // Outputs straight from flops
  assign req_ready               = rdy_q;
  assign rsp_valid               = rv_q;
  assign rsp_rdata               = rd_q;
  assign pins                    = pins_q;
  assign flash_reset_powerdown_n = rp_n_q;
  assign dq_o                    = dqo_q;
  assign dq_oe                   = dqoe_q;

  // Checks on the bus this controller drives
  logic f_on;                                     // Flash selected
  logic s_on;                                     // SRAM selected
  logic [sbg_pkg::SBG_CNT_W-1:0] low_len_q;       // Cycles reset has been low
  assign f_on = !pins_q.flash_ce_n;
  assign s_on = !pins_q.sram_select_low_n && pins_q.sram_select_high;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      low_len_q <= '0;
    else if (rp_n_q)
      low_len_q <= '0;
    else if (low_len_q != '1)
      low_len_q <= low_len_q + 1'b1;
  end

  sequence s_cause_gone;
    pg_s && cpu_s;
  endsequence

  chk_sel_exclusive: assert property (@(posedge clk) disable iff (!rst_b)
    !(f_on && s_on)) else $error("flash and SRAM selected together");
  chk_switch_gap: assert property (@(posedge clk) disable iff (!rst_b)
    (f_on |=> !s_on) and (s_on |=> !f_on)) else $error("no gap between dies");
  chk_one_driver: assert property (@(posedge clk) disable iff (!rst_b)
    dqoe_q |-> pins_q.flash_oe_n && pins_q.sram_oe_n) else $error("bus contention");
  chk_restore_first: assert property (@(posedge clk) disable iff (!rst_b)
    !pins_q.flash_oe_n && cur_q.op == sbg_pkg::SBG_OP_READ |-> !dirty_q)
    else $error("array read without read-array");
  chk_reset_follow: assert property (@(posedge clk) disable iff (!rst_b)
    !cpu_s |=> !rp_n_q ##1 !rp_n_q) else $error("flash reset not following cpu");
  chk_reset_length: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rp_n_q) |-> $past(low_len_q) >= RST_N) else $error("flash reset too short");
  chk_reset_release: assert property (@(posedge clk) disable iff (!rst_b)
    !rp_n_q ##1 s_cause_gone [*8] |-> ##[1:40] rp_n_q) else $error("reset not released");
  chk_no_flash_rst: assert property (@(posedge clk) disable iff (!rst_b)
    !rp_n_q |=> !f_on) else $error("flash selected while in reset");

endmodule

// ===== sbg_mem_model.sv
// Behavioural stacked flash + SRAM part, seen only through its bus pins.
// Assumes a host that drives the data bus only while dq_oe is high.
`timescale 1ns/10ps
module sbg_mem_model #(
  parameter int ACC_NS = 70  // Read access time of both dies
) (
  // Control pins from the host
  input  wire sbg_pkg::sbg_pins_t pins,
  input  wire logic               flash_reset_powerdown_n,
  // Host side of the data bus
  input  wire logic [15:0]        dq_o,
  input  wire logic               dq_oe,
  // Bus level seen by the host, and the part's own drive
  output logic [15:0]             dq,
  output logic                    drv
);
  // Latched command state of the flash
  typedef enum logic [1:0]
  {
    SBG_M_ARR = 2'h0,
    SBG_M_STS = 2'h1,
    SBG_M_PRG = 2'h2,
    SBG_M_ERS = 2'h3
  } sbg_mode_t;

  localparam logic [15:0] STS_READY = 16'h0080;  // Status word, part idle

  logic [15:0] flash_mem [16];  // Small flash array, low address bits
  logic [15:0] sram_mem [16];   // Small SRAM array
  sbg_mode_t   mode;            // Changes only by writes or reset
  logic [15:0] last;            // Last value that anyone drove
  logic [15:0] rd_val;          // Word the selected die would return
  logic [3:0]  a;               // Word index
  logic        sram_sel;        // SRAM selected by both selects
  logic        rd_any;          // Some die is asked to drive
  logic        rd_ok;           // Access time has run out

  // Erased flash, read-array mode at power-up
  initial
  begin
    for (int i = 0; i < 16; i++)
      flash_mem[i] = 16'hffff;
    mode = SBG_M_ARR;
    last = 16'h0000;
    rd_ok = 1'b0;
  end

  assign a = pins.addr[3:0];
  assign sram_sel = !pins.sram_select_low_n && pins.sram_select_high;

  // Command front end: reset wins at once, writes need strobe and select
  always @(posedge pins.flash_we_n or negedge flash_reset_powerdown_n)
  begin
    if (!flash_reset_powerdown_n)
      mode <= SBG_M_ARR;
    else if (!pins.flash_ce_n)
    begin
      if (mode == SBG_M_PRG)
        flash_mem[a] <= flash_mem[a] & dq;
      if (mode == SBG_M_ERS && dq[7:0] == 8'hd0)
        for (int i = 0; i < 16; i++)
          flash_mem[i] <= 16'hffff;
      if (mode == SBG_M_PRG || mode == SBG_M_ERS)
        mode <= SBG_M_STS;  // Stays in status afterwards
      else
        case (dq[7:0])
          8'hff: mode <= SBG_M_ARR;
          8'h70: mode <= SBG_M_STS;
          8'h40, 8'h10: mode <= SBG_M_PRG;
          8'h20: mode <= SBG_M_ERS;
          default: mode <= mode;
        endcase
    end
  end

  // SRAM writes ignore the flash state entirely
  always @(posedge pins.sram_we_n)
    if (sram_sel)
      sram_mem[a] <= dq;

  // Read path; flash silent while held in reset
  assign rd_any = (sram_sel && !pins.sram_oe_n)
    || (!pins.flash_ce_n && !pins.flash_oe_n && flash_reset_powerdown_n);
  assign rd_val = (sram_sel && !pins.sram_oe_n) ? sram_mem[a]
    : (mode == SBG_M_ARR ? flash_mem[a] : STS_READY);

  // Data appears only after the access time
  always @(rd_any)
  begin
    rd_ok = 1'b0;
    rd_ok <= #(ACC_NS) rd_any;
  end
  assign drv = rd_any && rd_ok;

  // Released bus shows the inverse of the last driven word
  always @(dq_oe, dq_o, drv, rd_val)
    if (dq_oe)
      last = dq_o;
    else if (drv)
      last = rd_val;
  assign dq = dq_oe ? dq_o : (drv ? rd_val : ~last);
endmodule

// ===== sbg_host_tb.sv
// Self-checking bench for the shared-bus flash/SRAM host controller.
// Assumes the behavioural part model on the far side of the pins.
`timescale 1ns/10ps
module sbg_host_tb;
  logic               clk, rst_b, cpu_reset_b, power_good;
  logic               req_valid, req_ready, rsp_valid;
  logic               rp_n, dq_oe, drv;
  logic [15:0]        rsp_rdata, dq_i, dq_o, rd;
  sbg_pkg::sbg_req_t  req;
  sbg_pkg::sbg_pins_t pins;
  int                 n_mismatch, num_checks;

  // Clock, 10 ns period
  initial clk = 1'b0;
  always #5 clk = ~clk;

  sbg_host dut (.clk(clk), .rst_b(rst_b), .cpu_reset_b(cpu_reset_b),
    .power_good(power_good), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .pins(pins), .flash_reset_powerdown_n(rp_n), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe));
  sbg_mem_model #(.ACC_NS(70)) part (.pins(pins),
    .flash_reset_powerdown_n(rp_n), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq(dq_i), .drv(drv));

  // Compare a word result
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  // Compare a single-bit result
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  // One request: hold until taken, then wait for the response pulse
  task automatic do_op(input sbg_pkg::sbg_target_t t, input sbg_pkg::sbg_op_t op,
                       input logic [3:0] a, input logic [15:0] wd);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{target: t, op: op, addr: {16'h0000, a}, wdata: wd};
    repeat (300)
    begin
      @(posedge clk);
      if (req_ready === 1'b1)
        break;
    end
    check_bit(req_ready, 1'b1);
    req_valid <= 1'b0;
    repeat (60)
    begin
      @(posedge clk);
      if (rsp_valid === 1'b1)
        break;
    end
    check_bit(rsp_valid, 1'b1);
    rd = rsp_rdata;
  endtask

  // Read and compare in one step
  task automatic rd_chk(input sbg_pkg::sbg_target_t t, input sbg_pkg::sbg_op_t op,
                        input logic [3:0] a, input logic [15:0] exp);
    do_op(t, op, a, 16'h0000);
    check_word(rd, exp);
  endtask

  // SRAM words written and read back, flash idle
  task automatic t_sram;
    do_op(sbg_pkg::SBG_TGT_SRAM, sbg_pkg::SBG_OP_WRITE, 4'h5, 16'h1234);
    do_op(sbg_pkg::SBG_TGT_SRAM, sbg_pkg::SBG_OP_WRITE, 4'h6, 16'hedcb);
    rd_chk(sbg_pkg::SBG_TGT_SRAM, sbg_pkg::SBG_OP_READ, 4'h5, 16'h1234);
    rd_chk(sbg_pkg::SBG_TGT_SRAM, sbg_pkg::SBG_OP_READ, 4'h6, 16'hedcb);
    $display("test sram done");
  endtask

  // Both program codes, SRAM use while flash sits in status mode
  task automatic t_program;
    logic [15:0] code [2];
    code = '{16'h0040, 16'h0010};
    for (int i = 0; i < 2; i++)
    begin
      do_op(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_WRITE, 4'(3 + i), code[i]);
      do_op(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_WRITE, 4'(3 + i), 16'h5a5a);
      rd_chk(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_READ_RAW, 4'h0, 16'h0080);
      do_op(sbg_pkg::SBG_TGT_SRAM, sbg_pkg::SBG_OP_WRITE, 4'h9, code[i]);
      rd_chk(sbg_pkg::SBG_TGT_SRAM, sbg_pkg::SBG_OP_READ, 4'h9, code[i]);
      rd_chk(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_READ, 4'(3 + i), 16'h5a5a);
    end
    // A lone data write is no command and changes nothing
    do_op(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_WRITE, 4'h7, 16'h1234);
    rd_chk(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_READ, 4'h7, 16'hffff);
    $display("test program done");
  endtask

  // Erase code, status, then restored array reads
  task automatic t_erase;
    do_op(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_WRITE, 4'h0, 16'h0020);
    do_op(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_WRITE, 4'h0, 16'h00d0);
    rd_chk(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_READ_RAW, 4'h1, 16'h0080);
    rd_chk(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_READ, 4'h3, 16'hffff);
    $display("test erase done");
  endtask

  // Status mode survives until the processor reset pulls flash reset
  task automatic t_cpu_reset;
    do_op(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_WRITE, 4'h0, 16'h0070);
    rd_chk(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_READ, 4'h2, 16'h0080);
    cpu_reset_b <= 1'b0;
    repeat (5) @(posedge clk);
    check_bit(rp_n, 1'b0);
    cpu_reset_b <= 1'b1;
    repeat (10) @(posedge clk);
    check_bit(rp_n, 1'b0);
    repeat (30) @(posedge clk);
    check_bit(rp_n, 1'b1);
    rd_chk(sbg_pkg::SBG_TGT_FLASH, sbg_pkg::SBG_OP_READ_RAW, 4'h2, 16'hffff);
    $display("test cpu reset done");
  endtask

  // Power loss holds flash in reset, SRAM still usable
  task automatic t_power;
    power_good <= 1'b0;
    repeat (5) @(posedge clk);
    check_bit(rp_n, 1'b0);
    do_op(sbg_pkg::SBG_TGT_SRAM, sbg_pkg::SBG_OP_WRITE, 4'h1, 16'h0f0f);
    rd_chk(sbg_pkg::SBG_TGT_SRAM, sbg_pkg::SBG_OP_READ, 4'h1, 16'h0f0f);
    power_good <= 1'b1;
    repeat (40) @(posedge clk);
    check_bit(rp_n, 1'b1);
    $display("test power done");
  endtask

  // Selects never overlap, only one party on the data bus
  always @(negedge clk)
    if (rst_b)
    begin
      check_bit(!pins.flash_ce_n && !pins.sram_select_low_n && pins.sram_select_high,
        1'b0);
      check_bit(dq_oe && drv, 1'b0);
    end

  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #200us;
    n_mismatch++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    cpu_reset_b = 1'b1;
    power_good = 1'b1;
    req_valid = 1'b0;
    req = '0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    check_bit(pins === sbg_pkg::SBG_PINS_IDLE, 1'b1);
    check_bit(rp_n, 1'b0);
    rst_b <= 1'b1;
    $display("test reset done");
    t_sram();
    t_program();
    t_erase();
    t_cpu_reset();
    t_power();
    print_verdict();
  end
endmodule
